// >>> design/sgpwi_pkg.sv
// Shared constants and types for the flash protection host controller.
// Assumes a 40 MHz clock and an AXI4-Lite master with 32-bit data.
package sgpwi_pkg;

  // ==========================================================================
  // Clock and pin timing
  // ==========================================================================
  localparam int unsigned CLK_MHZ      = 40;
  localparam int unsigned T_SETUP_NS   = 20;     // Address/data setup before write strobe
  localparam int unsigned T_WP_NS      = 35;     // Write strobe low width
  localparam int unsigned T_WH_NS      = 20;     // Recovery after write strobe rises
  localparam int unsigned T_ACC_NS     = 70;     // Read access time
  localparam int unsigned T_RP_NS      = 500;    // Hard reset low pulse width
  localparam int unsigned T_POWERUP_NS = 50000;  // Quiet time after power-up
  localparam int unsigned SYNC_STAGES  = 2;      // Read data synchroniser depth

  // Least times round up to whole cycles
  localparam int unsigned SETUP_CYC   = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned WP_CYC      = (T_WP_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned WH_CYC      = (T_WH_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned ACC_CYC     = (T_ACC_NS * CLK_MHZ + 999) / 1000 + SYNC_STAGES;
  localparam int unsigned RP_CYC      = (T_RP_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned POWERUP_CYC = (T_POWERUP_NS * CLK_MHZ + 999) / 1000;

  // ==========================================================================
  // Register map (byte addresses)
  // ==========================================================================
  localparam logic [7:0] OFS_CTRL   = 8'h00;  // Op kind, write starts it
  localparam logic [7:0] OFS_ADDR   = 8'h04;  // Target flash address
  localparam logic [7:0] OFS_WDATA  = 8'h08;  // Data for the target cycle
  localparam logic [7:0] OFS_RDATA  = 8'h0C;  // Last read data
  localparam logic [7:0] OFS_STATUS = 8'h10;  // Engine state flags
  localparam logic [7:0] OFS_PINS   = 8'h14;  // Static pin levels

  localparam int unsigned ST_BUSY_BIT    = 0;
  localparam int unsigned ST_REFUSED_BIT = 1;
  localparam int unsigned ST_LOCKOUT_BIT = 2;
  localparam int unsigned ST_SECURED_BIT = 3;
  localparam int unsigned ST_READY_BIT   = 4;
  localparam int unsigned PIN_HV_BIT     = 0;
  localparam int unsigned PIN_WP_BIT     = 1;
  localparam int unsigned PIN_ALLP_BIT   = 2;
  localparam logic [2:0]  PINS_RESET     = 3'h2;  // Guard pin released high

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================================
  // Command sequence defaults
  // ==========================================================================
  localparam logic [20:0] UNLOCK1_ADDR = 21'h000AAA;
  localparam logic [15:0] UNLOCK1_DATA = 16'h00AA;
  localparam logic [20:0] UNLOCK2_ADDR = 21'h000555;
  localparam logic [15:0] UNLOCK2_DATA = 16'h0055;
  localparam logic [15:0] ENTER_SEC_CMD = 16'h0088;
  localparam logic [15:0] EXIT_SEC_CMD  = 16'h0090;
  localparam logic [1:0]  UNLOCK_LAST   = 2'h2;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [2:0] {
    OP_READ      = 3'b000,
    OP_WRITE     = 3'b001,
    OP_UNLK_WR   = 3'b010,
    OP_PROTECT   = 3'b011,
    OP_UNPROTECT = 3'b100,
    OP_SEC_ENTER = 3'b101,
    OP_SEC_EXIT  = 3'b110,
    OP_HW_RESET  = 3'b111
  } sgpwi_op_t;

  typedef enum logic [2:0] {
    S_POWERUP = 3'b000,
    S_IDLE    = 3'b001,
    S_SETUP   = 3'b010,
    S_STROBE  = 3'b011,
    S_RECOVER = 3'b100,
    S_RSTLOW  = 3'b101
  } sgpwi_state_t;

  typedef struct packed {
    logic [20:0] addr;       // Flash address pins
    logic [15:0] dq;         // Data driven to the flash
    logic        dq_oe;      // High while the host drives data
    logic        ce_n;       // Chip select, active low
    logic        oe_n;       // Output enable, active low
    logic        we_n;       // Write strobe, active low
    logic        reset_n;    // Hard reset, active low
    logic        high_voltage_level;  // Raise reset pin to elevated level
    logic        wp_n;       // Boot write-guard level
  } sgpwi_pins_t;

endpackage : sgpwi_pkg

// >>> design/sgpwi_host.sv
// Host controller that drives a parallel NOR flash protection interface.
// Assumes an AXI4-Lite master, a 40 MHz clock and asynchronous flash inputs.
//
// Local design decisions: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none

module sgpwi_host (
  input  wire logic                 clk,             // 40 MHz clock
  input  wire logic                 rst,             // Synchronous reset, high
  input  wire logic [7:0]           s_axi_awaddr,    // Write address
  input  wire logic                 s_axi_awvalid,   // Write address valid
  output logic                      s_axi_awready,   // Write address ready
  input  wire logic [31:0]          s_axi_wdata,     // Write data
  input  wire logic [3:0]           s_axi_wstrb,     // Write byte enables
  input  wire logic                 s_axi_wvalid,    // Write data valid
  output logic                      s_axi_wready,    // Write data ready
  output logic [1:0]                s_axi_bresp,     // Write response
  output logic                      s_axi_bvalid,    // Write response valid
  input  wire logic                 s_axi_bready,    // Write response ready
  input  wire logic [7:0]           s_axi_araddr,    // Read address
  input  wire logic                 s_axi_arvalid,   // Read address valid
  output logic                      s_axi_arready,   // Read address ready
  output logic [31:0]               s_axi_rdata,     // Read data
  output logic [1:0]                s_axi_rresp,     // Read response
  output logic                      s_axi_rvalid,    // Read data valid
  input  wire logic                 s_axi_rready,    // Read data ready
  input  wire logic [15:0]          flash_dq_i,      // Data from the flash
  input  wire logic                 supply_lockout,  // Supply below lockout threshold
  output sgpwi_pkg::sgpwi_pins_t    flash_pins       // All flash control pins
);

  // ==========================================================================
  // State
  // ==========================================================================
  sgpwi_pkg::sgpwi_state_t state, next_state;
  sgpwi_pkg::sgpwi_op_t    op, next_op;
  sgpwi_pkg::sgpwi_pins_t  next_pins;
  logic [11:0] cnt, next_cnt;
  logic [1:0]  step, next_step;
  logic [20:0] addr_reg, next_addr_reg;
  logic [15:0] wdata_reg, next_wdata_reg;
  logic [15:0] rd_data, next_rd_data;
  logic [2:0]  pin_ctrl, next_pin_ctrl;
  logic        refused, next_refused;
  logic        secured, next_secured;
  logic        awready, next_awready;
  logic        bvalid, next_bvalid;
  logic [1:0]  bresp, next_bresp;
  logic        arready, next_arready;
  logic        rvalid, next_rvalid;
  logic [1:0]  rresp, next_rresp;
  logic [31:0] rdata, next_rdata;
  logic [15:0] dq_meta, dq_sync;
  logic        lock_meta, lock_sync;

  // Last step index of an op's sequence
  function automatic logic [1:0] last_step(input sgpwi_pkg::sgpwi_op_t o);
    if (o == sgpwi_pkg::OP_UNLK_WR || o == sgpwi_pkg::OP_SEC_ENTER ||
        o == sgpwi_pkg::OP_SEC_EXIT) begin
      return sgpwi_pkg::UNLOCK_LAST;
    end
    return 2'h0;
  endfunction : last_step

  // Pin image for the setup phase of one bus cycle
  function automatic sgpwi_pkg::sgpwi_pins_t cycle_pins(
      input sgpwi_pkg::sgpwi_pins_t p, input sgpwi_pkg::sgpwi_op_t o,
      input logic [1:0] s, input logic [20:0] a, input logic [15:0] d);
    sgpwi_pkg::sgpwi_pins_t r;
    r = p;
    r.ce_n = 1'b0;
    r.we_n = 1'b1;
    r.oe_n = (o == sgpwi_pkg::OP_READ) ? 1'b0 : 1'b1;
    r.dq_oe = (o == sgpwi_pkg::OP_READ) ? 1'b0 : 1'b1;
    r.addr = a;
    r.dq = d;
    if (s < last_step(o)) begin
      r.addr = (s == 2'h0) ? sgpwi_pkg::UNLOCK1_ADDR : sgpwi_pkg::UNLOCK2_ADDR;
      r.dq = (s == 2'h0) ? sgpwi_pkg::UNLOCK1_DATA : sgpwi_pkg::UNLOCK2_DATA;
    end else if (o == sgpwi_pkg::OP_SEC_ENTER) begin
      r.dq = sgpwi_pkg::ENTER_SEC_CMD;
    end else if (o == sgpwi_pkg::OP_SEC_EXIT) begin
      r.dq = sgpwi_pkg::EXIT_SEC_CMD;
    end
    return r;
  endfunction : cycle_pins

  // ==========================================================================
  // Input synchronisers
  // ==========================================================================
  // Flash data and lockout pass two flops before any logic reads them
  always_ff @(posedge clk) begin
    if (rst) begin
      dq_meta   <= 16'h0000;
      dq_sync   <= 16'h0000;
      lock_meta <= 1'b0;
      lock_sync <= 1'b0;
    end else begin
      dq_meta   <= flash_dq_i;
      dq_sync   <= dq_meta;
      lock_meta <= supply_lockout;
      lock_sync <= lock_meta;
    end
  end

  // ==========================================================================
  // Bus slave and pin engine, next values
  // ==========================================================================
  always_comb begin
    logic [31:0] wmask;
    logic        go;
    logic [31:0] merged;
    wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
             {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
    go = 1'b0;
    merged = 32'h0000_0000;
    next_state = state;
    next_op = op;
    next_pins = flash_pins;
    next_cnt = cnt;
    next_step = step;
    next_addr_reg = addr_reg;
    next_wdata_reg = wdata_reg;
    next_rd_data = rd_data;
    next_pin_ctrl = pin_ctrl;
    next_refused = refused;
    next_secured = secured;
    next_awready = 1'b0;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_arready = 1'b0;
    next_rvalid = rvalid;
    next_rresp = rresp;
    next_rdata = rdata;

    // Write channel: take address and data together, answer on B
    if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (s_axi_awvalid && s_axi_wvalid && !awready && !bvalid) begin
      next_awready = 1'b1;
      next_bvalid = 1'b1;
      next_bresp = sgpwi_pkg::RESP_OKAY;
      if (s_axi_awaddr == sgpwi_pkg::OFS_CTRL) begin
        go = s_axi_wstrb[0];
      end else if (s_axi_awaddr == sgpwi_pkg::OFS_ADDR) begin
        merged = ({11'h000, addr_reg} & ~wmask) | (s_axi_wdata & wmask);
        next_addr_reg = merged[20:0];
      end else if (s_axi_awaddr == sgpwi_pkg::OFS_WDATA) begin
        merged = ({16'h0000, wdata_reg} & ~wmask) | (s_axi_wdata & wmask);
        next_wdata_reg = merged[15:0];
      end else if (s_axi_awaddr == sgpwi_pkg::OFS_PINS) begin
        if (s_axi_wstrb[0]) begin
          next_pin_ctrl = s_axi_wdata[2:0];
        end
      end else if (s_axi_awaddr == sgpwi_pkg::OFS_RDATA ||
                   s_axi_awaddr == sgpwi_pkg::OFS_STATUS) begin
        next_bresp = sgpwi_pkg::RESP_OKAY;   // Read-only, write ignored
      end else begin
        next_bresp = sgpwi_pkg::RESP_SLVERR;
      end
    end

    // Read channel
    if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && !arready && !rvalid) begin
      next_arready = 1'b1;
      next_rvalid = 1'b1;
      next_rresp = sgpwi_pkg::RESP_OKAY;
      next_rdata = 32'h0000_0000;
      if (s_axi_araddr == sgpwi_pkg::OFS_CTRL) begin
        next_rdata = {29'h0000_0000, op};
      end else if (s_axi_araddr == sgpwi_pkg::OFS_ADDR) begin
        next_rdata = {11'h000, addr_reg};
      end else if (s_axi_araddr == sgpwi_pkg::OFS_WDATA) begin
        next_rdata = {16'h0000, wdata_reg};
      end else if (s_axi_araddr == sgpwi_pkg::OFS_RDATA) begin
        next_rdata = {16'h0000, rd_data};
      end else if (s_axi_araddr == sgpwi_pkg::OFS_STATUS) begin
        next_rdata[sgpwi_pkg::ST_BUSY_BIT] = (state != sgpwi_pkg::S_IDLE);
        next_rdata[sgpwi_pkg::ST_REFUSED_BIT] = refused;
        next_rdata[sgpwi_pkg::ST_LOCKOUT_BIT] = lock_sync;
        next_rdata[sgpwi_pkg::ST_SECURED_BIT] = secured;
        next_rdata[sgpwi_pkg::ST_READY_BIT] = (state != sgpwi_pkg::S_POWERUP);
      end else if (s_axi_araddr == sgpwi_pkg::OFS_PINS) begin
        next_rdata = {29'h0000_0000, pin_ctrl};
      end else begin
        next_rresp = sgpwi_pkg::RESP_SLVERR;
      end
    end

    // Static pin levels follow software at all times, during operations too
    next_pins.high_voltage_level = pin_ctrl[sgpwi_pkg::PIN_HV_BIT];
    next_pins.wp_n = pin_ctrl[sgpwi_pkg::PIN_WP_BIT];

    // Pin engine
    case (state)
      sgpwi_pkg::S_POWERUP: begin
        // Strobes held inactive until the flash has powered up
        if (cnt == 12'h000) begin
          next_state = sgpwi_pkg::S_IDLE;
        end else begin
          next_cnt = cnt - 12'h001;
        end
      end
      sgpwi_pkg::S_IDLE: begin
        if (go) begin
          next_op = sgpwi_pkg::sgpwi_op_t'(s_axi_wdata[2:0]);
          next_refused = 1'b0;
          next_step = 2'h0;
          if (lock_sync) begin
            next_refused = 1'b1;
          end else if ((next_op == sgpwi_pkg::OP_PROTECT ||
                        next_op == sgpwi_pkg::OP_UNPROTECT) &&
                       !pin_ctrl[sgpwi_pkg::PIN_HV_BIT]) begin
            next_refused = 1'b1;
          end else if (next_op == sgpwi_pkg::OP_UNPROTECT &&
                       !pin_ctrl[sgpwi_pkg::PIN_ALLP_BIT]) begin
            next_refused = 1'b1;
          end else if (next_op == sgpwi_pkg::OP_HW_RESET) begin
            next_pins.reset_n = 1'b0;
            next_cnt = 12'(sgpwi_pkg::RP_CYC - 1);
            next_state = sgpwi_pkg::S_RSTLOW;
          end else begin
            next_pins = cycle_pins(next_pins, next_op, 2'h0, addr_reg, wdata_reg);
            next_cnt = (next_op == sgpwi_pkg::OP_READ) ? 12'(sgpwi_pkg::ACC_CYC - 1)
                                                       : 12'(sgpwi_pkg::SETUP_CYC - 1);
            next_state = sgpwi_pkg::S_SETUP;
          end
        end else if (go) begin
          next_refused = 1'b1;
        end
      end
      sgpwi_pkg::S_SETUP: begin
        if (cnt != 12'h000) begin
          next_cnt = cnt - 12'h001;
        end else if (op == sgpwi_pkg::OP_READ) begin
          next_rd_data = dq_sync;
          next_pins.ce_n = 1'b1;
          next_pins.oe_n = 1'b1;
          next_cnt = 12'(sgpwi_pkg::WH_CYC - 1);
          next_state = sgpwi_pkg::S_RECOVER;
        end else begin
          next_pins.we_n = 1'b0;
          next_cnt = 12'(sgpwi_pkg::WP_CYC - 1);
          next_state = sgpwi_pkg::S_STROBE;
        end
      end
      sgpwi_pkg::S_STROBE: begin
        if (cnt != 12'h000) begin
          next_cnt = cnt - 12'h001;
        end else begin
          next_pins.we_n = 1'b1;
          next_pins.ce_n = 1'b1;
          next_cnt = 12'(sgpwi_pkg::WH_CYC - 1);
          next_state = sgpwi_pkg::S_RECOVER;
        end
      end
      sgpwi_pkg::S_RECOVER: begin
        if (cnt != 12'h000) begin
          next_cnt = cnt - 12'h001;
        end else if (step < last_step(op)) begin
          next_step = step + 2'h1;
          next_pins = cycle_pins(next_pins, op, step + 2'h1, addr_reg, wdata_reg);
          next_cnt = 12'(sgpwi_pkg::SETUP_CYC - 1);
          next_state = sgpwi_pkg::S_SETUP;
        end else begin
          next_pins.dq_oe = 1'b0;
          if (op == sgpwi_pkg::OP_SEC_ENTER) begin
            next_secured = 1'b1;
          end else if (op == sgpwi_pkg::OP_SEC_EXIT) begin
            next_secured = 1'b0;
          end
          next_state = sgpwi_pkg::S_IDLE;
        end
      end
      sgpwi_pkg::S_RSTLOW: begin
        if (cnt != 12'h000) begin
          next_cnt = cnt - 12'h001;
        end else begin
          next_pins.reset_n = 1'b1;
          next_secured = 1'b0;
          next_state = sgpwi_pkg::S_IDLE;
        end
      end
      default: begin
        next_state = sgpwi_pkg::S_IDLE;
      end
    endcase

    // Lockout aborts any cycle in flight and releases the bus
    if (lock_sync && state != sgpwi_pkg::S_IDLE && state != sgpwi_pkg::S_POWERUP) begin
      next_pins.ce_n = 1'b1;
      next_pins.we_n = 1'b1;
      next_pins.oe_n = 1'b1;
      next_pins.dq_oe = 1'b0;
      next_pins.reset_n = 1'b1;
      next_refused = 1'b1;
      next_state = sgpwi_pkg::S_IDLE;
    end
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge clk) begin
    if (rst) begin
      state      <= sgpwi_pkg::S_POWERUP;
      op         <= sgpwi_pkg::OP_READ;
      flash_pins <= '{addr: 21'h000000, dq: 16'h0000, dq_oe: 1'b0, ce_n: 1'b1,
                      oe_n: 1'b1, we_n: 1'b1, reset_n: 1'b1,
                      high_voltage_level: 1'b0, wp_n: 1'b1};
      cnt        <= 12'(sgpwi_pkg::POWERUP_CYC - 1);
      step       <= 2'h0;
      addr_reg   <= 21'h000000;
      wdata_reg  <= 16'h0000;
      rd_data    <= 16'h0000;
      pin_ctrl   <= sgpwi_pkg::PINS_RESET;
      refused    <= 1'b0;
      secured    <= 1'b0;
      awready    <= 1'b0;
      bvalid     <= 1'b0;
      bresp      <= 2'h0;
      arready    <= 1'b0;
      rvalid     <= 1'b0;
      rresp      <= 2'h0;
      rdata      <= 32'h0000_0000;
    end else begin
      state      <= next_state;
      op         <= next_op;
      flash_pins <= next_pins;
      cnt        <= next_cnt;
      step       <= next_step;
      addr_reg   <= next_addr_reg;
      wdata_reg  <= next_wdata_reg;
      rd_data    <= next_rd_data;
      pin_ctrl   <= next_pin_ctrl;
      refused    <= next_refused;
      secured    <= next_secured;
      awready    <= next_awready;
      bvalid     <= next_bvalid;
      bresp      <= next_bresp;
      arready    <= next_arready;
      rvalid     <= next_rvalid;
      rresp      <= next_rresp;
      rdata      <= next_rdata;
    end
  end

  assign s_axi_awready = awready;
  assign s_axi_wready  = awready;
  assign s_axi_bvalid  = bvalid;
  assign s_axi_bresp   = bresp;
  assign s_axi_arready = arready;
  assign s_axi_rvalid  = rvalid;
  assign s_axi_rresp   = rresp;
  assign s_axi_rdata   = rdata;

endmodule : sgpwi_host

`default_nettype wire

// >>> dv/sgpwi_flash_model.sv
// Bottom-boot flash model: group protection, guard pin, secured region.
// Assumes pins from sgpwi_host; a write commits on the rising strobe.
`timescale 1ns/1ps
`default_nettype none
module sgpwi_flash_model #(
  parameter logic LOCKED = 1'b0,  // Lock indicator bit value
  parameter logic TOP    = 1'b0   // High for a top-boot part
) (
  input  wire sgpwi_pkg::sgpwi_pins_t p,        // Pins from the host
  input  wire logic                   lockout,  // Supply below threshold
  output logic [15:0]                 dq_o      // Data to the host
);
  logic [15:0] mem [int];
  logic [16:0] prot = '0;
  logic [15:0] last = '0;
  logic        sel  = 1'b0;
  logic        sec  = 1'b0;
  logic        qry  = 1'b0;
  int          cnt  = 0;
  // ==========================================================
  // Group map and blocking
  // ==========================================================
  function automatic int grp(logic [20:0] a);
    a = a ^ {21{TOP}};  // Top boot is the bottom map mirrored
    if (a[20:16] == 5'h00) return int'(a[15:13]);
    if (a[20:16] == 5'h01) return 8;
    if (a[20:17] == 4'h1) return 9;
    return 9 + int'(a[20:18]);
  endfunction : grp
  function automatic logic [15:0] rd(logic [20:0] a);
    return mem.exists(a) ? mem[a] : 16'hFFFF;
  endfunction : rd
  // Floating guard reads high; raised reset pin lifts stored protection
  function automatic logic blk(int g);
    return (prot[g] && !p.high_voltage_level) || (g < 2 && p.wp_n === 1'b0);
  endfunction : blk
  // Qualify a write while the strobe is low
  always @(negedge p.we_n) sel = !p.ce_n && p.oe_n;
  // Supply loss or hard reset returns to array read
  always @(posedge lockout or negedge p.reset_n) begin
    cnt = 0;
    sec = 1'b0;
    qry = 1'b0;
  end
  // Command decoding
  always @(posedge p.we_n) begin
    if (lockout || !sel) cnt = 0;
    else if (cnt == 0 && p.addr == 21'hAAA && p.dq[7:0] == 8'hAA) cnt = 1;
    else if (cnt == 1 && p.addr == 21'h555 && p.dq[7:0] == 8'h55) cnt = 2;
    else if (cnt == 2) begin
      cnt = 0;
      if (p.dq == 16'h0088) sec = 1'b1;
      else if (p.dq == 16'h0090) {qry, sec} = {!sec, 1'b0};
      else if (!sec && !blk(grp(p.addr))) mem[p.addr] = rd(p.addr) & p.dq;
    end else begin
      cnt = 0;
      qry = 1'b0;
      if (p.high_voltage_level && p.dq[0]) prot[grp(p.addr)] = 1'b1;
      else if (p.high_voltage_level) prot = '0;
    end
  end
  // Read path; a released bus shows the inverse of the last word
  always @* if (!p.ce_n && !p.oe_n) last = qry ? {15'h0000, prot[grp(p.addr)]} :
    (sec && grp(p.addr) < 2) ? {8'hC3, LOCKED, 7'h2D} : rd(p.addr);
  assign dq_o = (!p.ce_n && !p.oe_n) ? last : ~last;
endmodule : sgpwi_flash_model
`default_nettype wire

// >>> dv/sgpwi_host_sva.sv
// Checker for the flash pins and the write address handshake of the host controller.
// Assumes one clock domain; bound to sgpwi_host below.
`timescale 1ns/1ps
`default_nettype none
module sgpwi_host_sva (
  input wire logic                   clk,             // Clock
  input wire logic                   rst,             // Reset
  input wire logic                   s_axi_awready,   // Write address ready
  input wire logic                   supply_lockout,  // Supply lockout
  input wire sgpwi_pkg::sgpwi_pins_t flash_pins       // Flash pins
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence strobe_s;
    !flash_pins.we_n [*2] ##1 flash_pins.we_n;
  endsequence
  wr_gate_a: assert property (!flash_pins.we_n |-> !flash_pins.ce_n && flash_pins.oe_n)
    else $error("strobe without select");
  strobe_wid_a: assert property ($fell(flash_pins.we_n) |-> strobe_s)
    else $error("strobe width wrong");
  dq_drive_a: assert property (!flash_pins.we_n |-> flash_pins.dq_oe)
    else $error("data not driven");
  read_gate_a: assert property (!flash_pins.oe_n |-> flash_pins.we_n && !flash_pins.dq_oe)
    else $error("read overlaps write");
  lock_idle_a: assert property (supply_lockout [*4] |-> flash_pins.we_n)
    else $error("strobe during lockout");
  pwr_quiet_a: assert property ($fell(rst) |-> flash_pins.ce_n [*8])
    else $error("select at power-up");
  hwrst_wid_a: assert property ($fell(flash_pins.reset_n) |-> !flash_pins.reset_n [*8])
    else $error("reset pulse short");
  aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready not a pulse");
endmodule : sgpwi_host_sva
bind sgpwi_host sgpwi_host_sva u_sgpwi_host_sva (.clk(clk), .rst(rst),
  .s_axi_awready(s_axi_awready), .supply_lockout(supply_lockout), .flash_pins(flash_pins));
`default_nettype wire

// >>> dv/sgpwi_host_tb_top.sv
// Testbench: drives the host over AXI4-Lite against the flash model.
// Assumes the checker is bound in by its own file.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin miscompares++; \
  $display("FAIL %s exp %h got %h", n, e, s); end end
module sgpwi_host_tb_top;
  logic clk = 0, rst = 1, lk = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, v;
  logic [1:0] bresp, rresp, br, rr;
  logic [15:0] dq, d;
  logic [15:0] mdl [int];
  sgpwi_pkg::sgpwi_pins_t pins;
  int miscompares = 0, comparisons = 0, cyc = 0, seed = 32'h34d06928;
  sgpwi_host u_sgpwi_host (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .flash_dq_i(dq), .supply_lockout(lk), .flash_pins(pins));
  sgpwi_flash_model u_sgpwi_flash_model (.p(pins), .lockout(lk), .dq_o(dq));
  // ==========================================================
  // Bus tasks
  // ==========================================================
  task automatic wr(input logic [7:0] a, input logic [31:0] x);
    awaddr <= a;
    wdata <= x;
    {awvalid, wvalid, bready} <= 3'h7;
    do @(posedge clk); while ((awready & wready) !== 1'b1);
    {awvalid, wvalid} <= 2'h0;
    while (bvalid !== 1'b1) @(posedge clk);
    br = bresp;
    bready <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] x);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge clk);
    x = rdata;
    rr = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask : rd
  task automatic op(input logic [2:0] o, input logic [20:0] a, input logic [15:0] x);
    wr(8'h04, 32'(a));
    wr(8'h08, 32'(x));
    wr(8'h00, 32'(o));
    do rd(8'h10, v); while (v[0] !== 1'b0);
  endtask : op
  task automatic chk_rd(input logic [20:0] a);
    op(3'h0, a, 16'h0);
    rd(8'h0C, v);
    `CHK("flash word", mdl.exists(a) ? mdl[a] : 16'hFFFF, v[15:0])
    `CHK("read resp", sgpwi_pkg::RESP_OKAY, rr)
  endtask : chk_rd
  // Random program; the model is updated only where protection allows it
  task automatic prog(input logic [20:0] a, input bit ok);
    d = 16'($random(seed)) | 16'h0100;
    op(3'h2, a, d);
    if (ok) mdl[a] = (mdl.exists(a) ? mdl[a] : 16'hFFFF) & d;
    chk_rd(a);
  endtask : prog
  task automatic wrap_up();
    if (miscompares == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up
  // ==========================================================
  // Clock, timeout and main sequence
  // ==========================================================
  initial forever #12.5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      wrap_up();
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(8'h14, v);
    `CHK("pins reset", 32'h2, v)
    rd(8'h10, v);
    `CHK("ready early", 1'b0, v[4])
    do rd(8'h10, v); while (v[4] !== 1'b1);
    wr(8'h20, 32'h0);
    `CHK("unmapped", sgpwi_pkg::RESP_SLVERR, br)
    prog(21'h040000, 1);
    op(3'h1, 21'h050000, 16'h1234);
    chk_rd(21'h050000);
    wr(8'h14, 32'h3);
    for (int g = 0; g < 17; g++) op(3'h3, g < 8 ? 21'(g << 13) : g == 8 ? 21'h10000 :
      g == 9 ? 21'h20000 : 21'((g - 9) << 18), 16'h1);
    wr(8'h14, 32'h2);
    op(3'h6, 21'h0, 16'h0);
    op(3'h0, 21'h040000, 16'h0);
    rd(8'h0C, v);
    `CHK("group status", 16'h0001, v[15:0])
    op(3'h1, 21'h0, 16'h00F0);
    prog(21'h040010, 0);
    wr(8'h14, 32'h3);
    prog(21'h040020, 1);
    wr(8'h14, 32'h2);
    prog(21'h040030, 0);
    wr(8'h14, 32'h7);
    op(3'h4, 21'h0, 16'h0);
    wr(8'h14, 32'h2);
    prog(21'h040040, 1);
    wr(8'h14, 32'h0);
    prog(21'h002000, 0);
    wr(8'h14, 32'h1);
    prog(21'h000000, 0);
    wr(8'h14, 32'h2);
    prog(21'h002000, 1);
    op(3'h5, 21'h0, 16'h0);
    `CHK("secured flag", 1'b1, v[3])
    op(3'h0, 21'h0, 16'h0);
    rd(8'h0C, v);
    `CHK("secured word", 16'hC32D, v[15:0])
    op(3'h6, 21'h0, 16'h0);
    chk_rd(21'h0);
    op(3'h5, 21'h0, 16'h0);
    op(3'h7, 21'h0, 16'h0);
    chk_rd(21'h0);
    lk <= 1'b1;
    op(3'h2, 21'h040050, 16'h0);
    rd(8'h10, v);
    `CHK("refused", 1'b1, v[1])
    `CHK("lockout flag", 1'b1, v[2])
    lk <= 1'b0;
    chk_rd(21'h040050);
    wrap_up();
  end
endmodule : sgpwi_host_tb_top
`default_nettype wire
